// file: design/fprc_top.sv
// Fan PWM rate and temperature span configuration registers
//
// Summary of operation
// RULE_01: Lock bit blocks writes to all three registers
// RULE_02: Each register resets to 0xcc
// RULE_03: Bits 2:0 pick low frequency PWM rate
// RULE_04: Bit 3 selects fast drive, mutes 3-wire settings
// RULE_05: Fast drive enable acts per fan register
// RULE_06: Bits 7:4 set automatic control temperature span
// RULE_07: Registers pair temperature source with PWM output
`timescale 1ns/100ps
`include "fprc_cfg.svh"

module fprc_top #(
    parameter int NCH = 3
) (
    input wire logic clk,
    input wire logic nrst,
    input wire fprc_pkg::fprc_wreq_t wreq,
    input wire logic [7:0] rd_addr,
    input wire logic cfg_lock,
    output logic [7:0] rd_data,
    output logic rd_hit,
    output logic [NCH*3-1:0] pwm_rate_select,
    output logic [NCH-1:0] fast_drive_enable,
    output logic [NCH-1:0] slow_fan_settings_active,
    output logic [NCH*4-1:0] temp_span,
    output logic [NCH*2-1:0] temp_source
);
    // Address map: one byte per fan channel, consecutive offsets
    // Byte layout, top down: span code, fast drive bit, rate code
    // Only codes leave here; the PWM generator and the control
    // loop next door turn them into periods and slopes
    //
    // Lock arrives as a same-clock level from its owner register,
    // so it takes no synchroniser; a locked write is dropped with
    // no flag, software sees it only by reading back
    //
    // Limitation: the offset table knows three channels; NCH above
    // three folds the extra channels onto the first offset, so one
    // write would land in several images at once
    //
    // Reads are registered so the field fan-out and the read port
    // both see one settled image per cycle; the price is one cycle
    // of read latency and a stale byte on a same-cycle write

    // Register images, one per fan channel
    fprc_pkg::fprc_chan_t regs [NCH];
    // Per channel write strobe after lock gating
    logic [NCH-1:0] wr_sel;
    // Per channel read selection
    logic [NCH-1:0] rd_sel;
    // Word picked for the read port
    logic [7:0] next_rd_data;

    // Channel address table
    function automatic logic [7:0] ch_addr(input int i);
        logic [7:0] a;
        a = `FPRC_OFS_CH1;
        if (i == 1)
            a = `FPRC_OFS_CH2;
        else if (i == 2)
            a = `FPRC_OFS_CH3;
        return a;
    endfunction

    // Per channel slice: decode, storage, fan-out and checks
    genvar g;
    generate
        for (g = 0; g < NCH; g++)
        begin : g_ch
            // Decode; lock drops the write silently
            assign wr_sel[g] = wreq.wr && !cfg_lock && // [RULE_01]
                (wreq.addr == ch_addr(g)); // [RULE_05]
            // Read decode, same table as the write side
            assign rd_sel[g] = (rd_addr == ch_addr(g));

            // Storage; power-on image
            always_ff @(posedge clk or negedge nrst)
            begin
                if (!nrst) // [RULE_02]
                    regs[g] <= fprc_pkg::fprc_chan_t'(`FPRC_RESET_VAL);
                else if (wr_sel[g])
                    regs[g] <= fprc_pkg::fprc_chan_t'(wreq.data);
            end

            // Field fan-out to the PWM and control logic
            // Rate code, turned into a period by the PWM generator
            assign pwm_rate_select[g*3 +: 3] =
                regs[g].pwm_rate_select; // [RULE_03]
            assign fast_drive_enable[g] =
                regs[g].fast_drive_enable; // [RULE_04] [RULE_05]
            // 3-wire only settings are ignored in fast drive
            assign slow_fan_settings_active[g] =
                !regs[g].fast_drive_enable; // [RULE_04]
            // Span code for the automatic control slope
            assign temp_span[g*4 +: 4] = regs[g].temp_span; // [RULE_06]
            // Fixed source pairing per channel
            assign temp_source[g*2 +: 2] = (g == 0) ? // [RULE_07]
                2'(fprc_pkg::FPRC_SRC_REMOTE1) : (g == 1) ?
                2'(fprc_pkg::FPRC_SRC_LOCAL) :
                2'(fprc_pkg::FPRC_SRC_REMOTE2);

            // Locked write leaves contents untouched
            a_lock_holds: assert property ( // [RULE_01]
                @(posedge clk) disable iff (!nrst)
                (wreq.wr && cfg_lock) |=> $stable(regs[g]))
                else $error("locked write changed a register");

            // Locked write also leaves the field outputs alone
            a_lock_fields: assert property ( // [RULE_01]
                @(posedge clk) disable iff (!nrst)
                (wreq.wr && cfg_lock) |=>
                $stable(temp_span[g*4 +: 4]) &&
                $stable(pwm_rate_select[g*3 +: 3]) &&
                $stable(fast_drive_enable[g]))
                else $error("locked write moved a field output");

            // Unlocked addressed write lands one cycle later
            a_write_lands: assert property ( // [RULE_05]
                @(posedge clk) disable iff (!nrst)
                (wreq.wr && !cfg_lock && wreq.addr == ch_addr(g)) |=>
                (regs[g] == $past(wreq.data)))
                else $error("unlocked write did not land");

            // A write to any other offset leaves this channel alone
            a_other_addr: assert property ( // [RULE_05]
                @(posedge clk) disable iff (!nrst)
                (wreq.wr && wreq.addr != ch_addr(g)) |=> $stable(regs[g]))
                else $error("write to another offset changed a channel");

            // Fast drive bit written turns the 3-wire settings off
            a_fast_mutes: assert property ( // [RULE_04]
                @(posedge clk) disable iff (!nrst)
                (wreq.wr && !cfg_lock && wreq.addr == ch_addr(g)) |=>
                (fast_drive_enable[g] == $past(wreq.data[`FPRC_FAST_BIT])) &&
                (slow_fan_settings_active[g] == !fast_drive_enable[g]))
                else $error("3-wire settings active in fast drive");

            // Field outputs show the power-on image right after reset
            a_reset_image: assert property ( // [RULE_02]
                @(posedge clk) $rose(nrst) |->
                ({temp_span[g*4 +: 4], fast_drive_enable[g],
                pwm_rate_select[g*3 +: 3]} == `FPRC_RESET_VAL))
                else $error("field outputs wrong after reset");

            // Reading this offset returns the stored byte next cycle
            a_read_each: assert property ( // [RULE_05]
                @(posedge clk) disable iff (!nrst)
                (rd_addr == ch_addr(g)) |=> (rd_data == $past(regs[g])))
                else $error("read of a channel returned a wrong byte");
        end
    endgenerate

    // Read mux; unmapped addresses read zero
    always_comb
    begin
        next_rd_data = 8'h00;
        for (int i = 0; i < NCH; i++)
            if (rd_sel[i])
                next_rd_data = regs[i];
    end

    // Registered read data
    always_ff @(posedge clk or negedge nrst)
    begin
        if (!nrst)
            rd_data <= 8'h00;
        else
            rd_data <= next_rd_data;
    end

    // Hit flag is combinational handshake
    assign rd_hit = |rd_sel;

    // Checks at module level, some on a single channel; per channel ones sit in
    // the generate loop above. Field checks compare outputs with
    // the bits of the write that fed them, so a swapped field or
    // a wrong bit position trips them
    // Reset image checked just after release
    a_reset_value: assert property ( // [RULE_02]
        @(posedge clk) $rose(nrst) |-> (regs[0] == `FPRC_RESET_VAL))
        else $error("reset value wrong");

    // Rate field follows the written bits of the first channel
    a_rate_field: assert property ( // [RULE_03]
        @(posedge clk) disable iff (!nrst)
        (wreq.wr && !cfg_lock && wreq.addr == `FPRC_OFS_CH1) |=>
        (pwm_rate_select[2:0] ==
        $past(wreq.data[`FPRC_RATE_MSB:`FPRC_RATE_LSB])))
        else $error("rate field mismatch");

    // Span field follows the written bits of the first channel
    a_span_field: assert property ( // [RULE_06]
        @(posedge clk) disable iff (!nrst)
        (wreq.wr && !cfg_lock && wreq.addr == `FPRC_OFS_CH1) |=>
        (temp_span[3:0] ==
        $past(wreq.data[`FPRC_SPAN_MSB:`FPRC_SPAN_LSB])))
        else $error("span field mismatch");

    // Each output carries its fixed temperature source
    a_src_pair: assert property ( // [RULE_07]
        @(posedge clk) disable iff (!nrst)
        temp_source[5:0] == 6'h24)
        else $error("source pairing wrong");

    // Read returns a register one cycle later
    a_read_path: assert property ( // [RULE_05]
        @(posedge clk) disable iff (!nrst)
        (rd_addr == `FPRC_OFS_CH2 && !wreq.wr) |=>
        (rd_data == regs[1]))
        else $error("read data wrong");

    // Unmapped offsets raise no hit and read as zero
    a_unmapped_zero: assert property ( // [RULE_05]
        @(posedge clk) disable iff (!nrst)
        (rd_addr < `FPRC_OFS_CH1 || rd_addr > `FPRC_OFS_CH3) |->
        !rd_hit ##1 (rd_data == 8'h00))
        else $error("unmapped offset did not read zero");

    // No write strobe reaches a register while the lock is high
    a_lock_gate: assert property ( // [RULE_01]
        @(posedge clk) disable iff (!nrst)
        cfg_lock |-> (wr_sel == '0))
        else $error("write strobe passed the lock");
endmodule

// file: design/fprc_cfg.svh
// Offsets, reset values, field positions and clock rate for fprc block
`ifndef FPRC_CFG_SVH
`define FPRC_CFG_SVH
`define FPRC_OFS_CH1 8'h5f
`define FPRC_OFS_CH2 8'h60
`define FPRC_OFS_CH3 8'h61
`define FPRC_RESET_VAL 8'hcc
`define FPRC_RATE_LSB 0
`define FPRC_RATE_MSB 2
`define FPRC_FAST_BIT 3
`define FPRC_SPAN_LSB 4
`define FPRC_SPAN_MSB 7
`define FPRC_CLK_HZ 125000000
`endif

// file: design/fprc_pkg.sv
// Types shared by the fan rate and slope configuration block
package fprc_pkg;
    // One channel's register image
    typedef struct packed {
        logic [3:0] temp_span;
        logic fast_drive_enable;
        logic [2:0] pwm_rate_select;
    } fprc_chan_t;
    // Register write request
    typedef struct packed {
        logic wr;
        logic [7:0] addr;
        logic [7:0] data;
    } fprc_wreq_t;
    // Temperature source feeding a channel
    typedef enum logic [1:0] {
        FPRC_SRC_REMOTE1,
        FPRC_SRC_LOCAL,
        FPRC_SRC_REMOTE2
    } fprc_src_t;
endpackage

// file: sim/fprc_fan_model.sv
// Fan motor model watching one channel's drive mode
`timescale 1ns/100ps
module fprc_fan_model (
    input wire logic clk,
    input wire logic fast,
    output logic four_wire
);
    // Fan takes the drive mode one edge late, like a real input stage
    always_ff @(posedge clk)
    begin
        four_wire <= fast;
    end
endmodule

// file: sim/fprc_top_tb.sv
// Self-checking bench for the fan rate and span registers
`timescale 1ns/100ps
module fprc_top_tb;
    logic clk = 0, nrst = 0, cfg_lock = 0, rd_req = 0, rd_v = 0, four;
    fprc_pkg::fprc_wreq_t wreq = '0; // Write request
    logic [7:0] rd_addr = 8'h00, rd_data, q[$], exp[3]; // Expected images
    logic [8:0] rate;
    logic [2:0] fast, slow;
    logic [11:0] span;
    logic [5:0] src;
    logic rd_hit;
    int mismatches = 0, cmp_count = 0, cyc = 0, seed = 47765;
    fprc_top i_fprc_top (.clk(clk), .nrst(nrst), .wreq(wreq),
        .rd_addr(rd_addr), .cfg_lock(cfg_lock), .rd_data(rd_data),
        .rd_hit(rd_hit), .pwm_rate_select(rate), .fast_drive_enable(fast),
        .slow_fan_settings_active(slow), .temp_span(span), .temp_source(src));
    fprc_fan_model i_fprc_fan_model (.clk(clk), .fast(fast[2]),
        .four_wire(four));
    // Clock, 8 ns period
    initial
    begin
        forever #4 clk = ~clk;
    end
    task chk(input string n, input logic [7:0] s, input logic [7:0] e);
        cmp_count++;
        if (s !== e)
        begin
            mismatches++;
            $display("MISMATCH %s exp %h seen %h", n, e, s);
        end
    endtask
    task summarize;
        $display("compares %0d mismatches %0d", cmp_count, mismatches);
        if (mismatches == 0 && cmp_count > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Read data lands one edge after the address
    always @(posedge clk) rd_v <= rd_req;
    // Watcher takes the oldest note; also cuts a hang short
    always @(negedge clk)
    begin
        if (rd_v)
            chk("rd_data", rd_data, q.pop_front());
        cyc++;
        if (cyc > 3000)
        begin
            mismatches++;
            summarize();
        end
    end
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        rd_addr = a;
        rd_req = 1;
        q.push_back(e);
        @(negedge clk);
        chk("rd_hit", 8'(rd_hit), 8'(a >= 8'h5f && a <= 8'h61));
        rd_req = 0;
    endtask
    task wr(input int c, input logic [7:0] d);
        @(negedge clk);
        wreq = {1'b1, 8'h5f + c[7:0], d};
        if (!cfg_lock)
            exp[c] = d;
        @(negedge clk);
        wreq.wr = 0;
    endtask
    // Field outputs against the expected images
    task fields;
        for (int i = 0; i < 3; i++)
        begin
            chk("rate", 8'(rate[i*3+:3]), 8'(exp[i][2:0]));
            chk("fast", 8'(fast[i]), 8'(exp[i][3]));
            chk("slow", 8'(slow[i]), 8'(!exp[i][3]));
            chk("span", 8'(span[i*4+:4]), 8'(exp[i][7:4]));
            chk("src", 8'(src[i*2+:2]), i[7:0]);
        end
        chk("fan", 8'(four), 8'(exp[2][3]));
    endtask
    // Main sequence
    initial
    begin
        logic [7:0] d;
        for (int i = 0; i < 3; i++)
            exp[i] = 8'hcc;
        repeat (4) @(negedge clk);
        nrst = 1;
        fields();
        for (int i = 0; i < 3; i++)
            rd(8'h5f + 8'(i), 8'hcc);
        $display("reset test done");
        // Every rate and span code, random fast bit
        for (int k = 0; k < 16; k++)
        begin
            d = 8'($random(seed));
            d[7:4] = k[3:0];
            d[2:0] = k[2:0];
            wr(k % 3, d);
            rd(8'h5f + 8'(k % 3), exp[k % 3]);
            fields();
        end
        $display("write test done");
        // Locked writes must leave all three contents alone
        cfg_lock = 1;
        for (int c = 0; c < 3; c++)
            wr(c, ~exp[c]);
        for (int c = 0; c < 3; c++)
            rd(8'h5f + 8'(c), exp[c]);
        fields();
        cfg_lock = 0;
        // Writes land again once the lock drops
        wr(2, 8'h13);
        rd(8'h61, exp[2]);
        fields();
        rd(8'h62, 8'h00);
        $display("lock test done");
        // Reset in mid-run brings every register back to its image
        @(negedge clk);
        nrst = 0;
        repeat (2) @(negedge clk);
        nrst = 1;
        for (int i = 0; i < 3; i++)
            exp[i] = 8'hcc;
        fields();
        for (int i = 0; i < 3; i++)
            rd(8'h5f + 8'(i), 8'hcc);
        $display("reset rerun test done");
        summarize();
    end
endmodule
